// [irq_status_defines.svh]
`ifndef IRQ_STATUS_DEFINES_SVH
`define IRQ_STATUS_DEFINES_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define ADDR_W 18
`define IDX_GROUP_A 16'hfe04
`define IDX_GROUP_B 16'hfe05
`define IDX_GROUP_C 16'hfe06
`define IDX_TICK_CTRL 16'hfe07

// ****************************************************************
// Reset values
// ****************************************************************
`define STATUS_RESET 8'h00
`define TICK_CTRL_RESET 8'h00

// ****************************************************************
// Timebase control fields
// ****************************************************************
`define TICK_RATE_LSB 0
`define TICK_RATE_W 3
`define TICK_IE_BIT 3
`define TICK_ACK_BIT 4
`define TICK_FLAG_BIT 5
`define TICK_CNT_W 24
`define TICK_TAP_BASE 5'd8

// ****************************************************************
// Pending flag positions and vector numbers
// ****************************************************************
`define NUM_SRC 16
`define VEC_W 5
`define VEC_NONE 5'd0
`define VEC_EXT 5'd1
`define VEC_KEY 5'd14
`define KEY_PINS 5

`endif

// [irq_status_pkg.sv]
package irq_status_pkg;

  // Recognition states for the CPU side
  typedef enum logic [0:0] {
    REC_IDLE,
    REC_PRESENT
  } rec_state_t;

endpackage : irq_status_pkg

// [irq_rec_if.sv]
`timescale 1ns/1ps
`include "irq_status_defines.svh"

interface irq_rec_if;
  logic [`NUM_SRC:1] pend;
  logic mask;
  logic boundary;
  logic ack;
  logic req;
  logic [`VEC_W-1:0] vec;

  modport src (output pend, output mask, output boundary, output ack, input req, input vec);
  modport rec (input pend, input mask, input boundary, input ack, output req, output vec);
endinterface : irq_rec_if

// [irq_recognizer.sv]
`timescale 1ns/1ps
`include "irq_status_defines.svh"

module irq_recognizer
  import irq_status_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  irq_rec_if.rec ifc
);

  typedef struct packed {
    rec_state_t st;
    logic req;
    logic [`VEC_W-1:0] vec;
  } rec_st_t;

  rec_st_t st_q;
  rec_st_t st_d;
  logic [`VEC_W-1:0] best;

  // ****************************************************************
  // Pick the lowest numbered pending source
  // ****************************************************************
  always_comb begin
    best = `VEC_NONE;
    for (int i = `NUM_SRC; i >= 1; i--) begin
      if (ifc.pend[i]) begin
        best = `VEC_W'(i);
      end
    end
  end

  // Present one request; once latched it holds until acknowledged
  always_comb begin
    st_d = st_q;
    case (st_q.st)
      REC_IDLE: begin
        // Checked only at an instruction boundary with the mask clear
        if (ifc.boundary && !ifc.mask && (|ifc.pend)) begin
          st_d.st = REC_PRESENT;
          st_d.req = 1'b1;
          st_d.vec = best;
        end
      end
      REC_PRESENT: begin
        if (ifc.ack) begin
          st_d.st = REC_IDLE;
          st_d.req = 1'b0;
        end
      end
      default: begin
        st_d = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign ifc.req = st_q.req;
  assign ifc.vec = st_q.vec;

  // ****************************************************************
  // Checks
  // ****************************************************************
  lowest_first_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(st_q.req) |-> ((($past(ifc.pend) >> (st_q.vec - 5'd1)) & 16'h0001) == 16'h0001)
      && (($past(ifc.pend) & ((16'h0001 << (st_q.vec - 5'd1)) - 16'h0001)) == 16'h0000))
    else $error("request taken is not the highest priority pending");

  global_mask_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_q.st == REC_IDLE && ifc.mask) |=> !st_q.req)
    else $error("request raised while the global mask was set");

  vec_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_q.req && !ifc.ack) |=> st_q.req && $stable(st_q.vec))
    else $error("presented vector changed before acknowledge");

endmodule : irq_recognizer

// [interrupt_source_status.sv]
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "irq_status_defines.svh"

module interrupt_source_status
  import irq_status_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Avalon-MM slave
  input wire logic [`ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Pins
  input wire logic ext_request_pin_n_i,
  input wire logic [`KEY_PINS-1:0] key_pins_n_i,
  // Clock generator
  input wire logic pll_locked_i,
  input wire logic pll_change_ie_i,
  input wire logic pll_flag_clr_i,
  output logic pll_change_flag_o,
  // Timers
  input wire logic [1:0] timer_wrap_flag_i,
  input wire logic [1:0] timer_wrap_ie_i,
  input wire logic [2:0] chan_event_flag_i,
  input wire logic [2:0] chan_event_ie_i,
  // SPI
  input wire logic spi_rx_full_flag_i,
  input wire logic spi_rx_ie_i,
  input wire logic spi_tx_empty_flag_i,
  input wire logic spi_tx_ie_i,
  input wire logic spi_select_fault_flag_i,
  input wire logic spi_select_fault_en_i,
  input wire logic spi_overflow_flag_i,
  input wire logic spi_error_ie_i,
  // Serial port
  input wire logic uart_tx_empty_flag_i,
  input wire logic uart_tx_ie_i,
  input wire logic uart_tx_done_flag_i,
  input wire logic uart_tx_done_ie_i,
  input wire logic uart_rx_full_flag_i,
  input wire logic uart_rx_ie_i,
  input wire logic line_quiet_flag_i,
  input wire logic line_quiet_ie_i,
  input wire logic uart_overrun_flag_i,
  input wire logic uart_overrun_ie_i,
  input wire logic uart_noise_flag_i,
  input wire logic uart_noise_ie_i,
  input wire logic uart_frame_err_flag_i,
  input wire logic uart_frame_err_ie_i,
  input wire logic uart_parity_err_flag_i,
  input wire logic uart_parity_err_ie_i,
  // Converter
  input wire logic conv_done_i,
  input wire logic conv_ie_i,
  input wire logic conv_done_or_route_sel_i,
  input wire logic conv_clear_i,
  // Timebase
  output logic tick_wrap_flag_o,
  // CPU recognition
  input wire logic cpu_mask_i,
  input wire logic insn_boundary_i,
  input wire logic irq_ack_i,
  output logic irq_req_o,
  output logic [`VEC_W-1:0] irq_vec_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic [`KEY_PINS-1:0] key_s1;
    logic [`KEY_PINS-1:0] key_s2;
    logic ext_lat;
    logic key_lat;
    logic lock_q;
    logic pll_flag;
    logic conv_lat;
    logic [`TICK_CNT_W-1:0] tick_cnt;
    logic [`TICK_RATE_W-1:0] tick_rate;
    logic tick_ie;
    logic tick_flag;
    logic [`NUM_SRC:1] pend;
    logic wait_q;
    logic [31:0] rdata;
  } main_st_t;

  // Pin synchronisers idle high so reset does not fake a request
  localparam main_st_t ST_RESET = '{
    ext_s1: 1'b1,
    ext_s2: 1'b1,
    key_s1: '1,
    key_s2: '1,
    tick_rate: 3'(`TICK_CTRL_RESET),
    pend: {`STATUS_RESET, `STATUS_RESET},
    wait_q: 1'b1,
    default: '0
  };

  main_st_t st_q;
  main_st_t st_d;

  irq_rec_if ifc ();

  logic sel_a;
  logic sel_b;
  logic sel_c;
  logic sel_ctrl;
  logic wr_go;
  logic ack_wr;
  logic tick_roll;
  logic [4:0] tick_shamt;
  logic [`TICK_CNT_W-1:0] tick_mask;
  logic [`NUM_SRC:1] pend_d;
  logic [7:0] rd_byte;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign sel_a = (avs_address_i == {`IDX_GROUP_A, 2'b00});
  assign sel_b = (avs_address_i == {`IDX_GROUP_B, 2'b00});
  assign sel_c = (avs_address_i == {`IDX_GROUP_C, 2'b00});
  assign sel_ctrl = (avs_address_i == {`IDX_TICK_CTRL, 2'b00});
  // A write takes effect only at the edge where waitrequest is seen low
  assign wr_go = avs_write_i && !st_q.wait_q;
  assign ack_wr = wr_go && sel_ctrl && avs_byteenable_i[0] && avs_writedata_i[`TICK_ACK_BIT];

  // ****************************************************************
  // Timebase counter chain
  // ****************************************************************
  // Tap moves up two bits per rate step, so each step is a quarter rate
  always_comb begin
    tick_shamt = `TICK_TAP_BASE + {1'b0, st_q.tick_rate, 1'b0};
    tick_mask = (`TICK_CNT_W'(1) << tick_shamt) - `TICK_CNT_W'(1);
    tick_roll = ((st_q.tick_cnt & tick_mask) == tick_mask);
  end

  // ****************************************************************
  // Status flag composition
  // ****************************************************************
  // Peripheral flags reflect only enabled requests, pin latches at 1 and 14 always; position gives priority
  always_comb begin
    pend_d = '0;
    pend_d[1] = st_q.ext_lat;
    pend_d[2] = st_q.pll_flag && pll_change_ie_i;
    pend_d[3] = chan_event_flag_i[0] && chan_event_ie_i[0];
    pend_d[4] = chan_event_flag_i[1] && chan_event_ie_i[1];
    pend_d[5] = timer_wrap_flag_i[0] && timer_wrap_ie_i[0];
    pend_d[6] = chan_event_flag_i[2] && chan_event_ie_i[2];
    pend_d[7] = 1'b0; // Reserved source
    pend_d[8] = timer_wrap_flag_i[1] && timer_wrap_ie_i[1];
    pend_d[9] = (spi_rx_full_flag_i && spi_rx_ie_i)
      || (spi_select_fault_flag_i && spi_select_fault_en_i && spi_error_ie_i)
      || (spi_overflow_flag_i && spi_error_ie_i);
    pend_d[10] = spi_tx_empty_flag_i && spi_tx_ie_i;
    pend_d[11] = (uart_overrun_flag_i && uart_overrun_ie_i)
      || (uart_noise_flag_i && uart_noise_ie_i)
      || (uart_frame_err_flag_i && uart_frame_err_ie_i)
      || (uart_parity_err_flag_i && uart_parity_err_ie_i);
    pend_d[12] = (uart_rx_full_flag_i && uart_rx_ie_i)
      || (line_quiet_flag_i && line_quiet_ie_i);
    pend_d[13] = (uart_tx_empty_flag_i && uart_tx_ie_i)
      || (uart_tx_done_flag_i && uart_tx_done_ie_i);
    pend_d[14] = st_q.key_lat;
    // Route select set means no CPU request from the converter
    pend_d[15] = st_q.conv_lat && conv_ie_i && !conv_done_or_route_sel_i;
    pend_d[16] = st_q.tick_flag && st_q.tick_ie;
  end

  // ****************************************************************
  // Read data mux
  // ****************************************************************
  // Unused positions read zero; unmapped addresses read zero too
  always_comb begin
    rd_byte = 8'h00;
    if (sel_a) begin
      rd_byte = {st_q.pend[6:1], 2'b00};
    end else if (sel_b) begin
      rd_byte = st_q.pend[14:7];
    end else if (sel_c) begin
      rd_byte = {6'h00, st_q.pend[16:15]};
    end else if (sel_ctrl) begin
      rd_byte = {2'b00, st_q.tick_flag, 1'b0, st_q.tick_ie, st_q.tick_rate};
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    // Two-flop synchronisers on the request pins
    st_d.ext_s1 = ext_request_pin_n_i;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.key_s1 = key_pins_n_i;
    st_d.key_s2 = st_q.key_s1;
    // External latches: a still-low pin wins over the acknowledge
    if (irq_ack_i && ifc.vec == `VEC_EXT) begin
      st_d.ext_lat = 1'b0;
    end
    if (!st_q.ext_s2) begin
      st_d.ext_lat = 1'b1;
    end
    if (irq_ack_i && ifc.vec == `VEC_KEY) begin
      st_d.key_lat = 1'b0;
    end
    if (st_q.key_s2 != {`KEY_PINS{1'b1}}) begin
      st_d.key_lat = 1'b1;
    end
    // Lock change in either direction sets the PLL flag
    st_d.lock_q = pll_locked_i;
    if (pll_flag_clr_i) begin
      st_d.pll_flag = 1'b0;
    end
    if (pll_locked_i != st_q.lock_q) begin
      st_d.pll_flag = 1'b1;
    end
    // Converter completion held until data read or control write
    if (conv_clear_i) begin
      st_d.conv_lat = 1'b0;
    end
    if (conv_done_i && conv_ie_i) begin
      st_d.conv_lat = 1'b1;
    end
    // Timebase: rollover beats a simultaneous acknowledge
    st_d.tick_cnt = st_q.tick_cnt + `TICK_CNT_W'(1);
    if (ack_wr) begin
      st_d.tick_flag = 1'b0;
    end
    if (tick_roll) begin
      st_d.tick_flag = 1'b1;
    end
    if (wr_go && sel_ctrl && avs_byteenable_i[0]) begin
      st_d.tick_rate = avs_writedata_i[`TICK_RATE_LSB +: `TICK_RATE_W];
      st_d.tick_ie = avs_writedata_i[`TICK_IE_BIT];
    end
    // Status registers follow live requests; writes never touch them
    st_d.pend = pend_d;
    // One wait cycle, then answer with registered data
    if ((avs_read_i || avs_write_i) && st_q.wait_q) begin
      st_d.wait_q = 1'b0;
      st_d.rdata = {24'h000000, rd_byte};
    end else begin
      st_d.wait_q = 1'b1;
    end
  end

  // Clock enable low freezes everything, bus included
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_RESET;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Recognition
  // ****************************************************************
  assign ifc.pend = st_q.pend;
  assign ifc.mask = cpu_mask_i;
  assign ifc.boundary = insn_boundary_i;
  assign ifc.ack = irq_ack_i;

  irq_recognizer u_rec (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ifc(ifc.rec)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_readdata_o = st_q.rdata;
  assign avs_waitrequest_o = st_q.wait_q;
  assign pll_change_flag_o = st_q.pll_flag;
  assign tick_wrap_flag_o = st_q.tick_flag;
  assign irq_req_o = ifc.req;
  assign irq_vec_o = ifc.vec;

  // ****************************************************************
  // Checks
  // ****************************************************************
  ext_pin_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && !st_q.ext_s2) |=> (st_q.ext_lat and (ce_i |=> st_q.pend[1])))
    else $error("external pin low but request not latched");

  key_pin_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && st_q.key_s2 != {`KEY_PINS{1'b1}}) |=> st_q.key_lat)
    else $error("keyboard pin low but request not latched");

  pll_change_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && pll_locked_i != st_q.lock_q) |=> st_q.pll_flag)
    else $error("lock change did not set the PLL flag");

  spi_error_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && spi_overflow_flag_i && spi_error_ie_i) |=> st_q.pend[9])
    else $error("enabled SPI overflow not shown in status");

  uart_error_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && uart_parity_err_flag_i && !uart_parity_err_ie_i && !uart_overrun_flag_i
      && !uart_noise_flag_i && !uart_frame_err_flag_i) |=> !st_q.pend[11])
    else $error("disabled parity error raised serial error status");

  conv_request_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && conv_done_i && conv_ie_i && !conv_clear_i) ##1
      (ce_i && conv_ie_i && !conv_done_or_route_sel_i) |=> st_q.pend[15])
    else $error("converter completion raised no status flag");

  tick_ack_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && ack_wr && !tick_roll) |=> !st_q.tick_flag)
    else $error("timebase acknowledge did not clear the flag");

  tick_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && tick_roll) |=> st_q.tick_flag)
    else $error("timebase rollover did not set the flag");

  status_zero_bits_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!avs_waitrequest_o && avs_read_i && $past(sel_a)) |->
      avs_readdata_o[1:0] == 2'b00 && avs_readdata_o[31:8] == 24'h000000)
    else $error("unused status bits did not read zero");

  reserved_src_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_q.pend[7] == 1'b0)
    else $error("reserved status flag is set");

  bus_answer_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus access not answered after one wait cycle");

endmodule : interrupt_source_status

// [cpu_partner.sv]
`timescale 1ns/1ps

// ****************************************
// CPU recognition partner
// ****************************************
module cpu_partner (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic [1:0] ack_delay_i,
  input wire logic req_i,
  input wire logic [4:0] vec_i,
  output logic boundary_o,
  output logic mask_o,
  output logic ack_o,
  output logic [4:0] taken_vec_o
);
  typedef struct packed {
    logic [1:0] bcnt;
    logic [1:0] wcnt;
    logic ack;
    logic [4:0] vec;
  } cpu_state_t;
  cpu_state_t state_q;
  cpu_state_t state_d;

  // Ack after a chosen delay; never twice for one request, since req drops a cycle late
  always_comb begin
    state_d = state_q;
    state_d.bcnt = state_q.bcnt + 2'd1;
    state_d.ack = 1'b0;
    state_d.wcnt = 2'd0;
    if (req_i && !state_q.ack) begin
      if (state_q.wcnt == ack_delay_i) begin
        state_d.ack = 1'b1;
        state_d.vec = vec_i;
      end else begin
        state_d.wcnt = state_q.wcnt + 2'd1;
      end
    end
  end

  // Registered state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // One instruction ends every fourth cycle
  assign boundary_o = &state_q.bcnt;
  assign mask_o = hold_i;
  assign ack_o = state_q.ack;
  assign taken_vec_o = state_q.vec;
endmodule : cpu_partner

// [test_interrupt_source_status.sv]
`timescale 1ns/1ps
`include "irq_status_defines.svh"

module test_interrupt_source_status;
  import irq_status_pkg::*;
  localparam logic [17:0] GA = 18'h3f810;
  localparam logic [17:0] GB = 18'h3f814;
  localparam logic [17:0] GC = 18'h3f818;
  localparam logic [17:0] TC = 18'h3f81c;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [17:0] adr = '0;
  logic rd_s = 0, wr_s = 0, pin_n = 1, locked = 0, pll_ie = 0, pll_clr = 0, hold = 1;
  logic cdone = 0, cie = 0, croute = 0, cclr = 0, ce = 1;
  logic [31:0] wdat = '0;
  logic [4:0] keys_n = 5'h1f;
  logic [17:0] f = '0, e = '0;
  logic [1:0] dly = '0;
  logic [31:0] rdat;
  logic wreq, pflag, tflag, req, mask, bnd, ack;
  logic [4:0] vec, tvec;
  int errors = 0, total_checks = 0, cyc = 0;

  always #2.5 mclk_i = ~mclk_i;

  interrupt_source_status dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .ext_request_pin_n_i(pin_n), .key_pins_n_i(keys_n), .pll_locked_i(locked),
    .pll_change_ie_i(pll_ie), .pll_flag_clr_i(pll_clr), .pll_change_flag_o(pflag),
    .timer_wrap_flag_i(f[1:0]), .timer_wrap_ie_i(e[1:0]), .chan_event_flag_i(f[4:2]),
    .chan_event_ie_i(e[4:2]), .spi_rx_full_flag_i(f[5]), .spi_rx_ie_i(e[5]),
    .spi_tx_empty_flag_i(f[6]), .spi_tx_ie_i(e[6]), .spi_select_fault_flag_i(f[7]),
    .spi_select_fault_en_i(e[7]), .spi_overflow_flag_i(f[8]), .spi_error_ie_i(e[17]),
    .uart_tx_empty_flag_i(f[9]), .uart_tx_ie_i(e[9]), .uart_tx_done_flag_i(f[10]),
    .uart_tx_done_ie_i(e[10]), .uart_rx_full_flag_i(f[11]), .uart_rx_ie_i(e[11]),
    .line_quiet_flag_i(f[12]), .line_quiet_ie_i(e[12]), .uart_overrun_flag_i(f[13]),
    .uart_overrun_ie_i(e[13]), .uart_noise_flag_i(f[14]), .uart_noise_ie_i(e[14]),
    .uart_frame_err_flag_i(f[15]), .uart_frame_err_ie_i(e[15]),
    .uart_parity_err_flag_i(f[16]), .uart_parity_err_ie_i(e[16]), .conv_done_i(cdone),
    .conv_ie_i(cie), .conv_done_or_route_sel_i(croute), .conv_clear_i(cclr),
    .tick_wrap_flag_o(tflag), .cpu_mask_i(mask), .insn_boundary_i(bnd), .irq_ack_i(ack),
    .irq_req_o(req), .irq_vec_o(vec));

  cpu_partner cpu (.mclk_i(mclk_i), .rst_i(rst_i), .hold_i(hold), .ack_delay_i(dly),
    .req_i(req), .vec_i(vec), .boundary_o(bnd), .mask_o(mask), .ack_o(ack),
    .taken_vec_o(tvec));

  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  // Enabled peripheral flags, grouped per status bit
  function automatic logic [16:1] expp(input logic [17:0] fl, input logic [17:0] en);
    logic [17:0] g;
    logic [16:1] p;
    g = fl & en;
    p = '0;
    p[3] = g[2];
    p[4] = g[3];
    p[5] = g[0];
    p[6] = g[4];
    p[8] = g[1];
    p[9] = g[5] | ((fl[8] | g[7]) & en[17]);
    p[10] = g[6];
    p[11] = |g[16:13];
    p[12] = g[11] | g[12];
    p[13] = g[9] | g[10];
    return p;
  endfunction : expp

  function automatic logic [4:0] lowest(input logic [16:1] p);
    logic [4:0] r;
    r = 5'd0;
    for (int i = 16; i >= 1; i--) if (p[i]) r = i[4:0];
    return r;
  endfunction : lowest

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr <= a;
    rd_s <= !w;
    wr_s <= w;
    wdat <= {24'h0, d};
    do begin
      @(posedge mclk_i);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    chk("waitrequest", 32'h0, {31'h0, wreq});
    q = rdat[7:0];
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask : bus

  task automatic rdchk(input string nm, input logic [17:0] a, input logic [7:0] ex);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, ex}, {24'h0, q});
  endtask : rdchk

  // Let the CPU take one request, then mask again and let any late one drain
  task automatic take(input logic [4:0] ex);
    int n;
    n = 0;
    hold <= 1'b0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 80);
    chk("vector", {27'h0, ex}, {27'h0, tvec});
    hold <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask : take

  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Hang guard; the whole run needs a few thousand cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [16:1] p;
    logic [7:0] q;
    realtime t0;
    void'($urandom(32'he6fa));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rdchk("group_a", GA, 8'h00);
    rdchk("group_b", GB, 8'h00);
    rdchk("group_c", GC, 8'h00);
    rdchk("tick_ctrl", TC, 8'h00);
    rdchk("unmapped", 18'h00000, 8'h00);
    $display("test reset done");
    // First pass all flags masked, second all enabled, third a lone parity error, then random mixes
    for (int it = 0; it < 14; it++) begin
      // Pass three: a lone disabled parity error must stay out of the status
      f <= (it < 2) ? '1 : (it == 2) ? 18'h10000 : 18'($urandom);
      e <= (it == 0 || it == 2) ? '0 : (it == 1) ? '1 : 18'($urandom);
      dly <= 2'($urandom);
      repeat (3) @(posedge mclk_i);
      p = expp(f, e);
      bus(1'b1, GB, 8'hff, q);
      rdchk("group_a", GA, {p[6:1], 2'b00});
      rdchk("group_b", GB, p[14:7]);
      rdchk("group_c", GC, {6'h0, p[16:15]});
      if (p != '0) take(lowest(p));
    end
    f <= '0;
    e <= '0;
    $display("test gating done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) pin_n <= 1'b0;
      else keys_n[$urandom % 5] <= 1'b0;
      repeat (3) @(posedge mclk_i);
      pin_n <= 1'b1;
      keys_n <= 5'h1f;
      repeat (6) @(posedge mclk_i);
      if (k == 0) rdchk("ext latch", GA, 8'h04);
      else rdchk("key latch", GB, 8'h80);
      take(k == 0 ? 5'd1 : 5'd14);
      rdchk("latch cleared", k == 0 ? GA : GB, 8'h00);
    end
    $display("test pins done");
    pll_ie <= 1'b1;
    locked <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("pll flag", 32'h1, {31'h0, pflag});
    rdchk("pll status", GA, 8'h08);
    pll_clr <= 1'b1;
    pll_ie <= 1'b0;
    @(posedge mclk_i);
    pll_clr <= 1'b0;
    locked <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("pll flag", 32'h1, {31'h0, pflag});
    rdchk("pll gated", GA, 8'h00);
    pll_clr <= 1'b1;
    @(posedge mclk_i);
    pll_clr <= 1'b0;
    $display("test pll done");
    for (int r = 0; r < 2; r++) begin
      cie <= 1'b1;
      croute <= r[0];
      cdone <= 1'b1;
      @(posedge mclk_i);
      cdone <= 1'b0;
      rdchk("conv status", GC, r == 0 ? 8'h01 : 8'h00);
      cclr <= 1'b1;
      @(posedge mclk_i);
      cclr <= 1'b0;
      rdchk("conv cleared", GC, 8'h00);
    end
    cie <= 1'b0;
    $display("test converter done");
    bus(1'b1, TC, 8'h08, q);
    for (int n = 0; n < 600 && tflag !== 1'b1; n++) @(posedge mclk_i);
    chk("tick flag", 32'h1, {31'h0, tflag});
    rdchk("tick status", GC, 8'h02);
    rdchk("tick_ctrl", TC, 8'h28);
    bus(1'b1, TC, 8'h18, q);
    rdchk("tick acked", GC, 8'h00);
    // Rate one: rollovers of the chain come 1024 cycles apart
    bus(1'b1, TC, 8'h11, q);
    for (int n = 0; n < 1100 && tflag !== 1'b1; n++) @(posedge mclk_i);
    t0 = $realtime;
    bus(1'b1, TC, 8'h11, q);
    @(posedge mclk_i);
    for (int n = 0; n < 1100 && tflag !== 1'b1; n++) @(posedge mclk_i);
    chk("tick period", 32'd1024, 32'(int'(($realtime - t0) / 5.0)));
    // Clock enable low: a pin pulse inside the frozen span must leave no latch
    ce <= 1'b0;
    pin_n <= 1'b0;
    repeat (6) @(posedge mclk_i);
    ce <= 1'b1;
    pin_n <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rdchk("frozen pin", GA, 8'h00);
    bus(1'b1, TC, 8'h00, q);
    $display("test timebase done");
    final_report();
  end
endmodule : test_interrupt_source_status
